// file: gsi_consts.vh
`ifndef GSI_CONSTS_VH
`define GSI_CONSTS_VH
// clock and timing figures
`define GSI_CLK_MHZ       100
`define GSI_US_PER_MS     1000
`define GSI_T_PWRUP_MS    14'h001E
`define GSI_T_REINIT_MS   14'h001E
`define GSI_T_STOP_MS     14'h01F4
`define GSI_T_FRC_MS      14'h0190
`define GSI_T_SHORT_MS    14'h0001
`define GSI_T_PERSIST_MS  14'h0320
`define GSI_T_SELFTST_MS  14'h2710
`define GSI_T_FACTORY_MS  14'h04B0
`define GSI_T_SINGLE_MS   14'h1388
`define GSI_T_RHT_MS      14'h0032
`define GSI_T_NONE_MS     14'h0000
// bus address and checksum
`define GSI_ADDR          7'h62
`define GSI_CRC_POLY      8'h31
`define GSI_CRC_INIT      8'hFF
// byte and bit positions inside write and read transactions
`define GSI_BYTE_CMD_LO   3'h1
`define GSI_BYTE_DAT_HI   3'h2
`define GSI_BYTE_DAT_LO   3'h3
`define GSI_BYTE_CRC      3'h4
`define GSI_NB_CMD        3'h2
`define GSI_NB_DATA       3'h5
`define GSI_BIT_LAST      3'h7
`define GSI_RB_CRC        2'h2
// command codes
`define GSI_C_START_PER   16'h21B1
`define GSI_C_READ_MEAS   16'hEC05
`define GSI_C_STOP_PER    16'h3F86
`define GSI_C_SET_TOFS    16'h241D
`define GSI_C_GET_TOFS    16'h2318
`define GSI_C_SET_ALT     16'h2427
`define GSI_C_GET_ALT     16'h2322
`define GSI_C_AMB_PRESS   16'hE000
`define GSI_C_FORCED_CAL  16'h362F
`define GSI_C_SET_ASC     16'h2416
`define GSI_C_GET_ASC     16'h2313
`define GSI_C_GET_ASC_TGT 16'h233F
`define GSI_C_START_LP    16'h21AC
`define GSI_C_DATA_RDY    16'hE4B8
`define GSI_C_PERSIST     16'h3615
`define GSI_C_SERIAL      16'h3682
`define GSI_C_SELF_TEST   16'h3639
`define GSI_C_FACTORY     16'h3632
`define GSI_C_REINIT      16'h3646
`define GSI_C_VARIANT     16'h202F
`define GSI_C_SINGLE      16'h219D
`define GSI_C_SINGLE_RHT  16'h2196
`define GSI_C_PWR_DOWN    16'h36E0
`define GSI_C_WAKE_UP     16'h36F6
`define GSI_C_SET_INIT_P  16'h2445
`define GSI_C_GET_INIT_P  16'h2340
`define GSI_C_SET_STD_P   16'h244E
`define GSI_C_GET_STD_P   16'h234B
`endif

// file: gsi_sync.v
`timescale 1ns/100ps
// two-flop synchroniser for one pin level
module gsi_sync #(
  parameter [0:0] INIT = 1'b1
) (
  input  wire mclk_in,
  input  wire rst_b_in,
  input  wire d_in,
  output reg  q_out
);

  reg meta_reg;

  // first flop feeds only the second
  always @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      meta_reg <= INIT;
      q_out    <= INIT;
    end
    else
    begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end

endmodule

// file: gsi_top.v
`timescale 1ns/100ps
`include "gsi_consts.vh"
module gsi_top #(
  parameter MS_CYC = `GSI_CLK_MHZ * `GSI_US_PER_MS
) (
  input  wire        mclk_in,
  input  wire        rst_b_in,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe_out,
  input  wire        data_ready_in,
  input  wire [15:0] rd_word_in,
  output reg         rd_next_out,
  output reg         cmd_valid_out,
  output reg  [15:0] cmd_code_out,
  output reg         cmd_has_data_out,
  output reg  [15:0] wr_data_out,
  output reg         meas_on_out,
  output reg         busy_out,
  output reg         ready_out
);

  localparam [31:0] MS_LAST = MS_CYC - 1;
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_ADDR = 7'h02;
  localparam [6:0] S_RX   = 7'h04;
  localparam [6:0] S_ACK  = 7'h08;
  localparam [6:0] S_TX   = 7'h10;
  localparam [6:0] S_MACK = 7'h20;
  localparam [6:0] S_WAIT = 7'h40;

  wire        scl_s;
  wire        sda_s;
  reg         scl_d_reg;
  reg         sda_d_reg;
  reg  [6:0]  state_reg;
  reg  [6:0]  nxt_reg;
  reg  [7:0]  sh_reg;
  reg  [7:0]  tx_reg;
  reg  [2:0]  bit_reg;
  reg  [2:0]  byte_reg;
  reg  [1:0]  rbyte_reg;
  reg         ack_reg;
  reg         wr_txn_reg;
  reg         cmd_ok_reg;
  reg         crc_ok_reg;
  reg         mack_ok_reg;
  reg  [15:0] cmd_reg;
  reg  [15:0] dat_reg;
  reg  [15:0] word_tx_reg;
  reg  [15:0] last_cmd_reg;
  reg         ld_reg;
  reg  [13:0] ld_ms_reg;
  reg  [13:0] ms_left_reg;
  reg  [31:0] pre_reg;
  wire [7:0]  sh_next = {sh_reg[6:0], sda_s};
  wire        scl_rise = scl_s & ~scl_d_reg;
  wire        scl_fall = ~scl_s & scl_d_reg;
  wire        start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire        stop_ev  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire        issue = wr_txn_reg & cmd_ok_reg & (byte_reg == `GSI_NB_CMD |
                      (byte_reg == `GSI_NB_DATA & crc_ok_reg));

  // checksum over one word, high byte first
  function [7:0] crc8;
    input [15:0] w;
    integer i;
    reg [7:0] c;
    begin
      c = `GSI_CRC_INIT;
      for (i = 15; i >= 0; i = i - 1)
        c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ `GSI_CRC_POLY)
                          : {c[6:0], 1'b0};
      crc8 = c;
    end
  endfunction

  // execution time in ms; all-ones marks an unknown code
  function [13:0] exec_ms;
    input [15:0] c;
    begin
      case (c)
        `GSI_C_START_PER, `GSI_C_START_LP: exec_ms = `GSI_T_NONE_MS;
        `GSI_C_STOP_PER:   exec_ms = `GSI_T_STOP_MS;
        `GSI_C_FORCED_CAL: exec_ms = `GSI_T_FRC_MS;
        `GSI_C_PERSIST:    exec_ms = `GSI_T_PERSIST_MS;
        `GSI_C_SELF_TEST:  exec_ms = `GSI_T_SELFTST_MS;
        `GSI_C_FACTORY:    exec_ms = `GSI_T_FACTORY_MS;
        `GSI_C_REINIT:     exec_ms = `GSI_T_REINIT_MS;
        `GSI_C_SINGLE:     exec_ms = `GSI_T_SINGLE_MS;
        `GSI_C_SINGLE_RHT: exec_ms = `GSI_T_RHT_MS;
        `GSI_C_WAKE_UP:    exec_ms = `GSI_T_REINIT_MS;
        `GSI_C_READ_MEAS, `GSI_C_SET_TOFS, `GSI_C_GET_TOFS,
        `GSI_C_SET_ALT, `GSI_C_GET_ALT, `GSI_C_AMB_PRESS,
        `GSI_C_SET_ASC, `GSI_C_GET_ASC, `GSI_C_GET_ASC_TGT,
        `GSI_C_DATA_RDY, `GSI_C_SERIAL, `GSI_C_VARIANT,
        `GSI_C_PWR_DOWN, `GSI_C_SET_INIT_P, `GSI_C_GET_INIT_P,
        `GSI_C_SET_STD_P, `GSI_C_GET_STD_P:
                           exec_ms = `GSI_T_SHORT_MS;
        default:           exec_ms = 14'h3FFF;
      endcase
    end
  endfunction

  // code may run now: known, and allowed in the current mode
  function cmd_allowed;
    input [15:0] c;
    input        meas;
    begin
      if (exec_ms(c) == 14'h3FFF)
        cmd_allowed = 1'b0;
      else if (!meas)
        cmd_allowed = 1'b1;
      else
        cmd_allowed = (c == `GSI_C_READ_MEAS) | (c == `GSI_C_STOP_PER) |
                      (c == `GSI_C_AMB_PRESS) | (c == `GSI_C_DATA_RDY);
    end
  endfunction

  // checksum of the word now being sent, so its top bit can be picked out
  wire [7:0]  crc_tx = crc8(word_tx_reg);

  // pin synchronisers
  gsi_sync #(.INIT(1'b1)) u_scl (
    .mclk_in  (mclk_in),
    .rst_b_in (rst_b_in),
    .d_in     (scl_in),
    .q_out    (scl_s)
  );
  gsi_sync #(.INIT(1'b1)) u_sda (
    .mclk_in  (mclk_in),
    .rst_b_in (rst_b_in),
    .d_in     (sda_in),
    .q_out    (sda_s)
  );

  // ms timer: power-up, soft reset and execution windows
  always @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ms_left_reg <= `GSI_T_PWRUP_MS;
      pre_reg     <= 32'h0000_0000;
      ready_out   <= 1'b0;
      busy_out    <= 1'b1;
    end
    else
    begin
      busy_out <= (ms_left_reg != `GSI_T_NONE_MS) | ld_reg;
      if (ms_left_reg == `GSI_T_NONE_MS)
        ready_out <= 1'b1;
      if (ld_reg)
      begin
        ms_left_reg <= ld_ms_reg;
        pre_reg     <= 32'h0000_0000;
      end
      else if (ms_left_reg != `GSI_T_NONE_MS)
      begin
        if (pre_reg == MS_LAST)
        begin
          pre_reg     <= 32'h0000_0000;
          ms_left_reg <= ms_left_reg - 14'h0001;
        end
        else
          pre_reg <= pre_reg + 32'h0000_0001;
      end
    end
  end

  // target bus engine, sampled on mclk at any legal bus speed
  always @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      state_reg <= S_IDLE;
      nxt_reg <= S_IDLE;
      sh_reg <= 8'h00;
      tx_reg <= 8'h00;
      bit_reg <= 3'h0;
      byte_reg <= 3'h0;
      rbyte_reg <= 2'h0;
      ack_reg <= 1'b0;
      wr_txn_reg <= 1'b0;
      cmd_ok_reg <= 1'b0;
      crc_ok_reg <= 1'b0;
      mack_ok_reg <= 1'b0;
      cmd_reg <= 16'h0000;
      dat_reg <= 16'h0000;
      word_tx_reg <= 16'h0000;
      last_cmd_reg <= 16'h0000;
      ld_reg <= 1'b0;
      ld_ms_reg <= 14'h0000;
      sda_out <= 1'b0;
      sda_oe_out <= 1'b0;
      rd_next_out <= 1'b0;
      cmd_valid_out <= 1'b0;
      cmd_code_out <= 16'h0000;
      cmd_has_data_out <= 1'b0;
      wr_data_out <= 16'h0000;
      meas_on_out <= 1'b0;
    end
    else
    begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      ld_reg <= 1'b0;
      rd_next_out <= 1'b0;
      cmd_valid_out <= 1'b0;
      // a finished write hands its command out at stop or restart
      if ((start_ev | stop_ev) & issue)
      begin
        cmd_valid_out <= 1'b1;
        cmd_code_out <= cmd_reg;
        cmd_has_data_out <= (byte_reg == `GSI_NB_DATA);
        last_cmd_reg <= cmd_reg;
        ld_reg <= 1'b1;
        ld_ms_reg <= exec_ms(cmd_reg);
        if (byte_reg == `GSI_NB_DATA)
          wr_data_out <= dat_reg;
        if (cmd_reg == `GSI_C_START_PER | cmd_reg == `GSI_C_START_LP)
          meas_on_out <= 1'b1;
        if (cmd_reg == `GSI_C_STOP_PER)
          meas_on_out <= 1'b0;
      end
      if (start_ev)
      begin
        state_reg <= S_ADDR;
        bit_reg <= 3'h0;
        byte_reg <= 3'h0;
        wr_txn_reg <= 1'b0;
        cmd_ok_reg <= 1'b0;
        crc_ok_reg <= 1'b0;
        sda_oe_out <= 1'b0;
      end
      else if (stop_ev)
      begin
        state_reg <= S_IDLE;
        wr_txn_reg <= 1'b0;
        sda_oe_out <= 1'b0;
      end
      else
      begin
        case (state_reg)
          S_ADDR, S_RX:
            if (scl_rise)
            begin
              sh_reg <= sh_next;
              bit_reg <= bit_reg + 3'h1;
              if (bit_reg == `GSI_BIT_LAST)
              begin
                state_reg <= S_ACK;
                if (state_reg == S_ADDR)
                begin
                  // address: ready, not busy, and data if measurement read
                  ack_reg <= (sh_next[7:1] == `GSI_ADDR) & ready_out &
                             ~busy_out & ~(sh_next[0] &
                             last_cmd_reg == `GSI_C_READ_MEAS &
                             ~data_ready_in);
                  nxt_reg <= sh_next[0] ? S_TX : S_RX;
                  wr_txn_reg <= ~sh_next[0];
                  word_tx_reg <= rd_word_in;
                  tx_reg <= rd_word_in[15:8];
                  rbyte_reg <= 2'h0;
                end
                else
                begin
                  byte_reg <= byte_reg + 3'h1;
                  nxt_reg <= S_RX;
                  case (byte_reg)
                    3'h0:
                    begin
                      cmd_reg[15:8] <= sh_next;
                      ack_reg <= 1'b1;
                    end
                    `GSI_BYTE_CMD_LO:
                    begin
                      cmd_reg[7:0] <= sh_next;
                      cmd_ok_reg <= cmd_allowed({cmd_reg[15:8], sh_next},
                                                meas_on_out);
                      ack_reg <= cmd_allowed({cmd_reg[15:8], sh_next},
                                             meas_on_out);
                    end
                    `GSI_BYTE_DAT_HI:
                    begin
                      dat_reg[15:8] <= sh_next;
                      ack_reg <= 1'b1;
                    end
                    `GSI_BYTE_DAT_LO:
                    begin
                      dat_reg[7:0] <= sh_next;
                      ack_reg <= 1'b1;
                    end
                    `GSI_BYTE_CRC:
                    begin
                      crc_ok_reg <= (crc8(dat_reg) == sh_next);
                      ack_reg <= (crc8(dat_reg) == sh_next);
                    end
                    default: ack_reg <= 1'b0;
                  endcase
                end
              end
            end
          S_ACK:
            if (scl_fall)
            begin
              if (sda_oe_out)
              begin
                // ack bit ends: release, or drive the first read bit if it is low, then go on
                bit_reg <= 3'h0;
                state_reg <= nxt_reg;
                sda_oe_out <= (nxt_reg == S_TX) & ~tx_reg[7];
              end
              else if (ack_reg)
                sda_oe_out <= 1'b1;
              else
                state_reg <= S_WAIT;
            end
          S_TX:
            if (scl_fall)
            begin
              bit_reg <= bit_reg + 3'h1;
              tx_reg <= {tx_reg[6:0], 1'b0};
              if (bit_reg == `GSI_BIT_LAST)
              begin
                state_reg <= S_MACK;
                sda_oe_out <= 1'b0;
              end
              else
                sda_oe_out <= ~tx_reg[6];
            end
          S_MACK:
            if (scl_rise)
            begin
              mack_ok_reg <= ~sda_s;
              if (~sda_s & rbyte_reg == `GSI_RB_CRC)
                rd_next_out <= 1'b1;
              if (sda_s)
                state_reg <= S_WAIT;
            end
            else if (scl_fall & mack_ok_reg)
            begin
              // next byte: low half, checksum, then a fresh word
              state_reg <= S_TX;
              bit_reg <= 3'h0;
              if (rbyte_reg == `GSI_RB_CRC)
              begin
                rbyte_reg <= 2'h0;
                word_tx_reg <= rd_word_in;
                tx_reg <= rd_word_in[15:8];
                sda_oe_out <= ~rd_word_in[15];
              end
              else if (rbyte_reg == 2'h0)
              begin
                rbyte_reg <= 2'h1;
                tx_reg <= word_tx_reg[7:0];
                sda_oe_out <= ~word_tx_reg[7];
              end
              else
              begin
                rbyte_reg <= `GSI_RB_CRC;
                tx_reg <= crc_tx;
                sda_oe_out <= ~crc_tx[7];
              end
            end
          S_IDLE, S_WAIT:
            sda_oe_out <= 1'b0;
          default:
            state_reg <= S_IDLE;
        endcase
      end
    end
  end

endmodule

// file: gsi_host.sv
`timescale 1ns/100ps
// bus controller model: owns the bus clock and pulls the data wire low
module gsi_host (
  input  wire mclk_in,
  input  wire sda_in,
  output reg  scl_out,
  output reg  sda_oe_out
);
  localparam int Q = 4;
  // clock stands high and data is released between frames
  initial
  begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  // wait k system clocks
  task automatic tick(input int k);
    repeat (k) @(posedge mclk_in);
  endtask
  // frame opener, also a repeated start from clock low
  task automatic start_c;
    tick(Q);
    sda_oe_out <= 1'b0;
    tick(Q);
    scl_out <= 1'b1;
    tick(Q);
    sda_oe_out <= 1'b1;
    tick(Q);
    scl_out <= 1'b0;
  endtask
  // frame closer: data rises while the clock is high
  task automatic stop_c;
    tick(Q);
    sda_oe_out <= 1'b1;
    tick(Q);
    scl_out <= 1'b1;
    tick(Q);
    sda_oe_out <= 1'b0;
    tick(Q);
  endtask
  // one 160 ns bit: data set while low, sampled mid high
  task automatic bit_slot(input logic b, output logic s);
    tick(Q);
    sda_oe_out <= ~b;
    tick(Q);
    scl_out <= 1'b1;
    tick(Q);
    s = sda_in;
    tick(Q);
    scl_out <= 1'b0;
  endtask
  // byte out, high bit first, then the target's acknowledge
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_slot(b[i], s);
    bit_slot(1'b1, s);
    ack = ~s;
  endtask
  // byte in with our own acknowledge; a low ack ends the read
  task automatic get_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_slot(1'b1, s);
      b[i] = s;
    end
    bit_slot(~ack, s);
  endtask
endmodule

// file: gsi_checker.sv
`timescale 1ns/100ps
`include "gsi_consts.vh"
// timing and ordering watch on the command interface ports and the bus clock and data-enable pins
module gsi_checker #(
  parameter MS_CYC = 100000
) (
  input wire        mclk_in,
  input wire        rst_b_in,
  input wire        scl_in,
  input wire        sda_oe_out,
  input wire        cmd_valid_out,
  input wire [15:0] cmd_code_out,
  input wire        meas_on_out,
  input wire        busy_out,
  input wire        ready_out
);
  localparam int T_UP = 30 * MS_CYC;
  localparam int T_STOP = 500 * MS_CYC;
  localparam int T_FCAL = 400 * MS_CYC;
  int busy_cnt;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  // length of the current busy window
  always @(posedge mclk_in or negedge rst_b_in)
    if (!rst_b_in)
      busy_cnt <= 0;
    else
      busy_cnt <= busy_out ? busy_cnt + 1 : 0;
  ready_stay_a: assert property (ready_out |=> ready_out)
    else $error("ready dropped");
  pwrup_time_a: assert property ($rose(ready_out) |->
    busy_cnt >= T_UP - 3 && busy_cnt <= T_UP + 3)
    else $error("power-up window length wrong");
  valid_pulse_a: assert property (cmd_valid_out |=> !cmd_valid_out)
    else $error("command strobe longer than a cycle");
  ack_ready_a: assert property ($rose(sda_oe_out) |-> ready_out)
    else $error("driving before ready");
  ack_idle_a: assert property ($rose(sda_oe_out) |-> !busy_out)
    else $error("answered while busy");
  sda_edge_a: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data changed while clock high");
  start_meas_a: assert property (cmd_valid_out ##1
    cmd_code_out == `GSI_C_START_PER |-> ##[0:2] meas_on_out)
    else $error("start did not enter measuring");
  stop_clear_a: assert property (cmd_valid_out ##1
    cmd_code_out == `GSI_C_STOP_PER |-> ##[0:3] (!meas_on_out && busy_out))
    else $error("stop did not leave measuring");
  stop_time_a: assert property ($fell(busy_out) &&
    cmd_code_out == `GSI_C_STOP_PER |->
    busy_cnt >= T_STOP - 4 && busy_cnt <= T_STOP + 4)
    else $error("stop window length wrong");
  fcal_time_a: assert property ($fell(busy_out) &&
    cmd_code_out == `GSI_C_FORCED_CAL |->
    busy_cnt >= T_FCAL - 4 && busy_cnt <= T_FCAL + 4)
    else $error("calibration window length wrong");
  read_time_a: assert property ($fell(busy_out) &&
    cmd_code_out == `GSI_C_READ_MEAS |->
    busy_cnt >= MS_CYC - 4 && busy_cnt <= MS_CYC + 4)
    else $error("read execution length wrong");
  cover property (cmd_valid_out && meas_on_out);
  cover property ($fell(busy_out) && cmd_code_out == `GSI_C_STOP_PER);
  cover property ($rose(sda_oe_out) && meas_on_out);
endmodule
bind gsi_top gsi_checker #(.MS_CYC(MS_CYC)) u_chk (
  .mclk_in(mclk_in), .rst_b_in(rst_b_in), .scl_in(scl_in),
  .sda_oe_out(sda_oe_out), .cmd_valid_out(cmd_valid_out),
  .cmd_code_out(cmd_code_out), .meas_on_out(meas_on_out),
  .busy_out(busy_out), .ready_out(ready_out)
);

// file: testbench.sv
`timescale 1ns/100ps
`include "gsi_consts.vh"
module testbench;
  localparam int MS = 20;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        rdy_in = 1'b0;
  logic [15:0] word_in = 16'hBEEF;
  wire         scl, sda, h_oe, d_sda, d_oe, rd_next, c_valid, c_dat;
  wire         meas, busy, ready;
  wire  [15:0] c_code, w_data;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          n_valid = 0;
  int          n_next = 0;
  logic  [2:0] n;
  logic        ok;
  logic [15:0] w;
  logic  [7:0] c;
  // wired-and data line with pull-up
  assign sda = ~h_oe & (d_oe ? d_sda : 1'b1);
  // clock and strobe counters
  always #5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    n_valid <= n_valid + (c_valid === 1'b1);
    n_next <= n_next + (rd_next === 1'b1);
  end
  gsi_top #(.MS_CYC(MS)) u_dut (
    .mclk_in(mclk), .rst_b_in(rst_b), .scl_in(scl), .sda_in(sda),
    .sda_out(d_sda), .sda_oe_out(d_oe), .data_ready_in(rdy_in),
    .rd_word_in(word_in), .rd_next_out(rd_next), .cmd_valid_out(c_valid),
    .cmd_code_out(c_code), .cmd_has_data_out(c_dat), .wr_data_out(w_data),
    .meas_on_out(meas), .busy_out(busy), .ready_out(ready)
  );
  gsi_host u_host (
    .mclk_in(mclk), .sda_in(sda), .scl_out(scl), .sda_oe_out(h_oe)
  );
  // checksum over one word, high bit first
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] r;
    r = `GSI_CRC_INIT;
    for (int i = 15; i >= 0; i--)
      r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? `GSI_CRC_POLY : 8'h00);
    return r;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask
  // write frame; stops early on a refused byte; k counts acked bytes
  task automatic send(input logic [15:0] cd, input logic [2:0] nb,
    input logic [15:0] d, input logic [7:0] cs, output logic [2:0] k);
    logic [7:0] b [0:5];
    logic a;
    b = '{{`GSI_ADDR, 1'b0}, cd[15:8], cd[7:0], d[15:8], d[7:0], cs};
    k = 3'h0;
    a = 1'b1;
    u_host.start_c();
    for (int i = 0; i <= nb && a; i++)
    begin
      u_host.put_byte(b[i], a);
      k = k + {2'b00, a};
    end
    u_host.stop_c();
    u_host.tick(8);
  endtask
  // read frame: one word and its checksum, then refuse the next byte
  task automatic fetch;
    logic [7:0] x;
    u_host.start_c();
    u_host.put_byte({`GSI_ADDR, 1'b1}, ok);
    if (ok)
    begin
      u_host.get_byte(1'b1, w[15:8]);
      u_host.get_byte(1'b1, w[7:0]);
      u_host.get_byte(1'b1, c);
      u_host.get_byte(1'b0, x);
    end
    u_host.stop_c();
  endtask
  task automatic wait_idle(input int lim, output int k);
    k = 0;
    while (busy !== 1'b0 && k < lim)
    begin
      @(posedge mclk);
      k++;
    end
  endtask
  task automatic t_power;
    int k;
    send(`GSI_C_START_PER, 3'h2, 16'h0000, 8'h00, n);
    chk(n, 0);
    chk(ready, 0);
    wait_idle(40 * MS, k);
    chk_rng(k, 30 * MS - 250, 30 * MS);
    chk(ready, 1);
    u_host.start_c();
    u_host.put_byte({7'h63, 1'b0}, ok);
    u_host.stop_c();
    chk(ok, 0);
  endtask
  task automatic t_meas;
    int k;
    int v;
    logic [15:0] bad [0:2];
    bad = '{`GSI_C_SET_TOFS, 16'h1234, `GSI_C_REINIT};
    v = n_valid;
    send(`GSI_C_START_PER, 3'h2, 16'h0000, 8'h00, n);
    chk(n, 3);
    chk(16'(n_valid - v), 1);
    chk(c_code, `GSI_C_START_PER);
    chk({meas, busy, c_dat}, 3'h4);
    foreach (bad[i])
    begin
      send(bad[i], 3'h2, 16'h0000, 8'h00, n);
      chk(n, 2);
    end
    chk(16'(n_valid - v), 1);
    send(`GSI_C_DATA_RDY, 3'h2, 16'h0000, 8'h00, n);
    chk(n, 3);
    wait_idle(2 * MS, k);
    send(`GSI_C_AMB_PRESS, 3'h5, 16'h03F5, crc8(16'h03F5), n);
    chk(n, 6);
    wait_idle(2 * MS, k);
    send(`GSI_C_READ_MEAS, 3'h2, 16'h0000, 8'h00, n);
    wait_idle(2 * MS, k);
    chk_rng(k, 1, MS);
    fetch();
    chk(ok, 0);
    rdy_in <= 1'b1;
    v = n_next;
    send(`GSI_C_READ_MEAS, 3'h2, 16'h0000, 8'h00, n);
    wait_idle(2 * MS, k);
    fetch();
    chk(ok, 1);
    chk(w, 16'hBEEF);
    chk(c, crc8(16'hBEEF));
    chk(16'(n_next - v), 1);
    rdy_in <= 1'b0;
  endtask
  task automatic t_stop;
    int k;
    send(`GSI_C_STOP_PER, 3'h2, 16'h0000, 8'h00, n);
    chk(n, 3);
    chk({meas, busy}, 2'h1);
    send(`GSI_C_START_PER, 3'h2, 16'h0000, 8'h00, n);
    chk(n, 0);
    wait_idle(600 * MS, k);
    chk_rng(k, 500 * MS - 400, 500 * MS);
  endtask
  task automatic t_write;
    int k;
    int v;
    send(`GSI_C_SET_ALT, 3'h5, 16'h1A2B, crc8(16'h1A2B), n);
    chk(n, 6);
    chk({c_dat, c_code}, {1'b1, `GSI_C_SET_ALT});
    chk(w_data, 16'h1A2B);
    wait_idle(2 * MS, k);
    v = n_valid;
    send(`GSI_C_SET_ALT, 3'h5, 16'h5555, crc8(16'h5555) ^ 8'h01, n);
    chk(n, 5);
    send(`GSI_C_SET_ALT, 3'h4, 16'h7777, 8'h00, n);
    chk(n, 5);
    chk(w_data, 16'h1A2B);
    chk(16'(n_valid - v), 0);
  endtask
  task automatic t_fcal;
    int k;
    send(`GSI_C_FORCED_CAL, 3'h5, 16'h01E0, crc8(16'h01E0), n);
    chk(n, 6);
    fetch();
    chk(ok, 0);
    wait_idle(500 * MS, k);
    chk_rng(k, 400 * MS - 400, 400 * MS);
    fetch();
    chk(ok, 1);
    chk(w, 16'hBEEF);
    chk(c, crc8(w));
  endtask
  // reinit, then the low-power periodic start and its stop
  task automatic t_reinit;
    int k;
    send(`GSI_C_REINIT, 3'h2, 16'h0000, 8'h00, n);
    chk(n, 3);
    wait_idle(40 * MS, k);
    chk_rng(k, 30 * MS - 40, 30 * MS);
    chk(ready, 1);
    send(`GSI_C_START_LP, 3'h2, 16'h0000, 8'h00, n);
    chk(n, 3);
    chk(meas, 1);
    send(`GSI_C_SET_ALT, 3'h2, 16'h0000, 8'h00, n);
    chk(n, 2);
    send(`GSI_C_STOP_PER, 3'h2, 16'h0000, 8'h00, n);
    chk({meas, busy}, 2'h1);
    wait_idle(600 * MS, k);
    chk_rng(k, 500 * MS - 40, 500 * MS);
  endtask
  task automatic close_out;
    if (mismatches == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // watchdog well beyond the expected run length
  initial
  begin
    repeat (80000) @(posedge mclk);
    mismatches++;
    close_out();
  end
  // reset, then the scenarios in order
  initial
  begin
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    t_power();
    t_meas();
    t_stop();
    t_write();
    t_fcal();
    t_reinit();
    close_out();
  end
endmodule
